// ---- uospc_pkg.sv ----
// Package with register map, field positions, timing and carrier types of the OTG status/power block.
package uospc_pkg;

  // Register byte offsets.
  localparam logic [7:0] STAT_OFF = 8'h00;
  localparam logic [7:0] CON_OFF  = 8'h04;
  localparam logic [7:0] PWRC_OFF = 8'h08;
  localparam logic [7:0] FLAG_OFF = 8'h0C;

  // Status and flag bit positions.
  localparam int ID_BIT   = 7;
  localparam int LS_BIT   = 5;
  localparam int SV_BIT   = 3;
  localparam int SE_BIT   = 2;
  localparam int VV_BIT   = 0;

  // Control bit positions.
  localparam int DPUP_BIT = 7;
  localparam int DMUP_BIT = 6;
  localparam int DPDN_BIT = 5;
  localparam int DMDN_BIT = 4;
  localparam int VON_BIT  = 3;
  localparam int SWP_BIT  = 2;
  localparam int VCHG_BIT = 1;
  localparam int VDIS_BIT = 0;

  // Power control bit positions.
  localparam int ACTP_BIT = 7;
  localparam int GRD_BIT  = 4;
  localparam int BUSY_BIT = 3;
  localparam int SUSP_BIT = 1;
  localparam int PWR_BIT  = 0;

  // Values after reset.
  localparam logic [7:0] CON_RST  = 8'h00;
  localparam logic [7:0] PWRC_RST = 8'h00;
  localparam logic [7:0] FLAG_RST = 8'h00;

  // Timing.
  localparam int CLK_PERIOD_NS   = 20;
  localparam int LINE_STABLE_US  = 1;
  localparam int LINE_STABLE_NS  = LINE_STABLE_US * 1000000;
  localparam int LINE_STABLE_CYC = (LINE_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_NS       = 100;
  localparam int SETTLE_CYC      = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Sampled pin levels.
  typedef struct packed {
    logic id;
    logic se0;
    logic jstate;
    logic sess_valid;
    logic sess_end;
    logic vbus_valid;
    logic activity;
  } uospc_pins_t;

  // Data line resistor controls.
  typedef struct packed {
    logic dplus_pullup_enable;
    logic dminus_pullup_enable;
    logic dplus_pulldown_enable;
    logic dminus_pulldown_enable;
  } uospc_pull_t;

  // Bus power controls.
  typedef struct packed {
    logic bus_power_on;
    logic bus_power_charge;
    logic bus_power_discharge;
  } uospc_vbus_t;

endpackage

// ---- uospc_top.sv ----
// Status, line control and power control registers of the OTG link logic.
// Function
// R01: Status bit 7 reads 1 with no cable or B cable, 0 with A cable.
// R02: Status bit 5 is 1 only when line state unchanged for the last 1 ms.
// R03: Status bit 3 shows whether bus power is above session valid.
// R04: Status bit 2 shows 1 when B-side bus power is below session valid.
// R05: Status bit 0 shows 1 when A-side bus power is above session valid.
// R06: All unimplemented bits, including 31 to 8, read as zero.
// R07: Control bits 7 to 4 enable D+ up, D- up, D+ down, D- down.
// R08: Software pull control selects written bits, otherwise hardware drives the resistors.
// R09: Bus power is driven while the power-on bit is set.
// R10: Bus is charged through a resistor while the charge bit is set.
// R11: Bus is discharged through a resistor while the discharge bit is set.
// R12: Activity pending sets on bus activity, clears when its interrupt is generated.
// R13: Sleep guard blocks sleep while activity is seen or a notification pends.
// R14: Busy reads 1 while enabled or still settling after disable.
// R15: Software must not trust status or write registers while disabled and busy.
// R16: Suspend gates the 48 MHz clock and puts the transceiver in low power.
// R17: With operation disabled, outputs are inactive, pins released, analog shut down; sleep_block still follows guard and activity while disabled.
// R18: Line change flag sets when stable 1 ms state differs from last reported.
// R19: Identity and bus power comparator changes set sticky write-one-to-clear flags.
// R20: Writes to the status register are ignored.
module uospc_top #(
  parameter int LINE_STABLE_CYCLES = uospc_pkg::LINE_STABLE_CYC
) (
  // Clock and reset.
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  // Register port.
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [31:0]          reg_rdata,
  // Pins and comparators, asynchronous.
  input  wire uospc_pkg::uospc_pins_t pins_in,
  // Neighbouring USB logic, same clock.
  input  wire uospc_pkg::uospc_pull_t hw_pull,
  input  wire logic                 act_irq_taken,
  // Controls toward the analog front end.
  output uospc_pkg::uospc_pull_t    pull_out,
  output uospc_pkg::uospc_vbus_t    vbus_out,
  output logic                      usb_clk_en,
  output logic                      xcvr_low_power,
  output logic                      pins_owned,
  output logic                      analog_en,
  output logic                      sleep_block
);

  localparam int PW = $bits(uospc_pkg::uospc_pins_t);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  logic [PW-1:0]          sync1_q;
  logic [PW-1:0]          sync2_q;
  uospc_pkg::uospc_pins_t pin_s;

  genvar gi;
  generate
    for (gi = 0; gi < PW; gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= pins_in[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  assign pin_s = uospc_pkg::uospc_pins_t'(sync2_q);

  ////////////////////////////////////////////////////////////////////////////
  // Register decode.
  logic       wr_stat;
  logic       wr_con;
  logic       wr_pwrc;
  logic       wr_flag;
  logic [7:0] con_q;
  logic [7:0] pwrc_q;
  logic [7:0] flags_q;

  // R20: status writes dropped
  assign wr_stat = reg_wr && (reg_addr == uospc_pkg::STAT_OFF);
  assign wr_con  = reg_wr && (reg_addr == uospc_pkg::CON_OFF);
  assign wr_pwrc = reg_wr && (reg_addr == uospc_pkg::PWRC_OFF);
  assign wr_flag = reg_wr && (reg_addr == uospc_pkg::FLAG_OFF);

  // R07: resistor control bits
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      con_q <= uospc_pkg::CON_RST;
    end else if (wr_con) begin
      con_q <= reg_wdata[7:0];
    end
  end

  // Only guard, suspend and enable are writable; pending and busy are hardware state.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pwrc_q <= uospc_pkg::PWRC_RST;
    end else if (wr_pwrc) begin
      pwrc_q[uospc_pkg::GRD_BIT]  <= reg_wdata[uospc_pkg::GRD_BIT];
      pwrc_q[uospc_pkg::SUSP_BIT] <= reg_wdata[uospc_pkg::SUSP_BIT];
      pwrc_q[uospc_pkg::PWR_BIT]  <= reg_wdata[uospc_pkg::PWR_BIT];
    end
  end

  logic pwr_en;
  logic suspend;
  logic guard;
  assign pwr_en  = pwrc_q[uospc_pkg::PWR_BIT];
  assign suspend = pwrc_q[uospc_pkg::SUSP_BIT];
  assign guard   = pwrc_q[uospc_pkg::GRD_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Line state stability.
  logic [1:0]  ls_now;
  logic [1:0]  ls_prev_q;
  logic [1:0]  ls_rep_q;
  logic [15:0] ls_cnt_q;
  logic        ls_changed;
  logic        line_stable;
  logic        ls_entry;
  logic [15:0] ls_max;

  assign ls_max     = 16'(LINE_STABLE_CYCLES);
  assign ls_now     = {pin_s.se0, pin_s.jstate};
  assign ls_changed = (ls_now != ls_prev_q);

  // R02: count unchanged cycles
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ls_prev_q <= 2'h0;
      ls_cnt_q  <= 16'h0000;
    end else begin
      ls_prev_q <= ls_now;
      if (ls_changed) begin
        ls_cnt_q <= 16'h0000;
      end else if (ls_cnt_q != ls_max) begin
        ls_cnt_q <= ls_cnt_q + 16'h0001;
      end
    end
  end

  // R02: stable after full window
  assign line_stable = (ls_cnt_q == ls_max) && !ls_changed;
  assign ls_entry    = (ls_cnt_q == ls_max - 16'h0001) && !ls_changed;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ls_rep_q <= 2'h0;
    end else if (ls_entry) begin
      ls_rep_q <= ls_prev_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky change flags, write one to clear; a set in the clearing cycle wins.
  // Identity and comparator edges are ignored until the synchronisers hold real pin levels, so reset alone raises no identity or bus power flag.
  logic [3:0] mon_now;
  logic [3:0] mon_q;
  logic [2:0] prime_q;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;

  assign mon_now = {pin_s.id, pin_s.sess_valid, pin_s.sess_end, pin_s.vbus_valid};

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mon_q   <= 4'h0;
      prime_q <= 3'h0;
    end else begin
      mon_q   <= mon_now;
      prime_q <= {prime_q[1:0], 1'b1};
    end
  end

  always_comb begin
    flag_set = 8'h00;
    // R19: comparator and identity changes
    flag_set[uospc_pkg::ID_BIT] = prime_q[2] && (mon_now[3] != mon_q[3]);
    flag_set[uospc_pkg::SV_BIT] = prime_q[2] && (mon_now[2] != mon_q[2]);
    flag_set[uospc_pkg::SE_BIT] = prime_q[2] && (mon_now[1] != mon_q[1]);
    flag_set[uospc_pkg::VV_BIT] = prime_q[2] && (mon_now[0] != mon_q[0]);
    // R18: new stable line state
    flag_set[uospc_pkg::LS_BIT] = ls_entry && (ls_prev_q != ls_rep_q);
  end

  assign flag_clr = wr_flag ? reg_wdata[7:0] : 8'h00;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      flags_q <= uospc_pkg::FLAG_RST;
    end else begin
      flags_q <= (flags_q & ~flag_clr) | flag_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Activity, sleep guard and busy.
  logic       act_q;
  logic       act_pend_q;
  logic [2:0] settle_q;
  logic       busy;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      act_q <= 1'b0;
    end else begin
      act_q <= pin_s.activity;
    end
  end

  // R12: pending until interrupt generated
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      act_pend_q <= 1'b0;
    end else if (pin_s.activity && !act_q) begin
      act_pend_q <= 1'b1;
    end else if (act_irq_taken) begin
      act_pend_q <= 1'b0;
    end
  end

  // R13: block sleep entry
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sleep_block <= 1'b0;
    end else begin
      sleep_block <= guard && (pin_s.activity || act_pend_q);
    end
  end

  // Analog parts need time to wind down, so busy outlasts the enable bit.
  // R14: settle after disable
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      settle_q <= 3'h0;
    end else if (pwr_en) begin
      settle_q <= 3'(uospc_pkg::SETTLE_CYC);
    end else if (settle_q != 3'h0) begin
      settle_q <= settle_q - 3'h1;
    end
  end

  assign busy = pwr_en || (settle_q != 3'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Outputs toward the front end.
  uospc_pkg::uospc_pull_t sw_pull;
  assign sw_pull = {con_q[uospc_pkg::DPUP_BIT], con_q[uospc_pkg::DMUP_BIT],
                    con_q[uospc_pkg::DPDN_BIT], con_q[uospc_pkg::DMDN_BIT]};

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pull_out       <= '0;
      vbus_out       <= '0;
      usb_clk_en     <= 1'b0;
      xcvr_low_power <= 1'b1;
      pins_owned     <= 1'b0;
      analog_en      <= 1'b0;
    end else begin
      // R17: disabled holds all inactive
      if (!pwr_en) begin
        pull_out <= '0;
        vbus_out <= '0;
      end else begin
        // R08: software or hardware pulls
        pull_out <= con_q[uospc_pkg::SWP_BIT] ? sw_pull : hw_pull;
        // R09: power, R10: charge, R11: discharge
        vbus_out <= {con_q[uospc_pkg::VON_BIT], con_q[uospc_pkg::VCHG_BIT], con_q[uospc_pkg::VDIS_BIT]};
      end
      // R16: suspend gates clock
      usb_clk_en     <= pwr_en && !suspend;
      xcvr_low_power <= !pwr_en || suspend;
      pins_owned     <= pwr_en;
      analog_en      <= pwr_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path; data stand only in the cycle after the strobe.
  logic [31:0] rd_d;

  always_comb begin
    rd_d = 32'h0000_0000;
    case (reg_addr)
      uospc_pkg::STAT_OFF: begin
        // R01: identity, R03: session valid, R04: session end, R05: A valid
        rd_d[uospc_pkg::ID_BIT] = pin_s.id;
        rd_d[uospc_pkg::LS_BIT] = line_stable;
        rd_d[uospc_pkg::SV_BIT] = pin_s.sess_valid;
        rd_d[uospc_pkg::SE_BIT] = pin_s.sess_end;
        rd_d[uospc_pkg::VV_BIT] = pin_s.vbus_valid;
      end
      uospc_pkg::CON_OFF:  rd_d[7:0] = con_q;
      uospc_pkg::PWRC_OFF: begin
        rd_d[uospc_pkg::ACTP_BIT] = act_pend_q;
        rd_d[uospc_pkg::GRD_BIT]  = guard;
        rd_d[uospc_pkg::BUSY_BIT] = busy;
        rd_d[uospc_pkg::SUSP_BIT] = suspend;
        rd_d[uospc_pkg::PWR_BIT]  = pwr_en;
      end
      uospc_pkg::FLAG_OFF: rd_d[7:0] = flags_q;
      default:             rd_d = 32'h0000_0000;
    endcase
  end

  // R06: upper bits always zero
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rd_d : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_stat_read: assert property (reg_rd && reg_addr == uospc_pkg::STAT_OFF |=>  // R01
    reg_rdata[7] == $past(pin_s.id) && reg_rdata[3] == $past(pin_s.sess_valid) &&
    reg_rdata[2] == $past(pin_s.sess_end) && reg_rdata[0] == $past(pin_s.vbus_valid))
    else $error("status read mismatch");
  a_ls_drop: assert property (ls_changed |-> !line_stable ##1 !line_stable)  // R02
    else $error("line stable despite change");
  a_ls_rise: assert property ($rose(line_stable) |-> $past(ls_cnt_q) == ls_max - 16'h0001)  // R02
    else $error("line stable too early");
  a_unimpl_zero: assert property (reg_rdata[31:8] == 24'h000000 &&  // R06
    ($past(reg_addr) == uospc_pkg::CON_OFF || reg_rdata[6] == 1'b0))
    else $error("unimplemented bits not zero");
  a_pull_sel: assert property (pwr_en && $stable(pwr_en) ##0 1'b1 |=>  // R08
    pull_out == ($past(con_q[uospc_pkg::SWP_BIT]) ? $past(sw_pull) : $past(hw_pull)))
    else $error("pull control source wrong");
  a_vbus_ctl: assert property (pwr_en |=> vbus_out.bus_power_on == $past(con_q[3]) &&  // R09
    vbus_out.bus_power_charge == $past(con_q[1]) && vbus_out.bus_power_discharge == $past(con_q[0]))
    else $error("bus power control wrong");
  a_act_pend: assert property (pin_s.activity && !act_q |=> act_pend_q)  // R12
    else $error("activity not pending");
  a_sleep_grd: assert property (!guard |=> !sleep_block)  // R13
    else $error("sleep blocked without guard");
  a_busy_tail: assert property ($fell(pwr_en) |-> busy [*5] ##1 !busy)  // R14
    else $error("busy settle length wrong");
  a_suspend: assert property (suspend |=> !usb_clk_en && xcvr_low_power)  // R16
    else $error("suspend not applied");
  a_disable: assert property (!pwr_en |=> pull_out == '0 && vbus_out == '0 && !pins_owned && !analog_en)  // R17
    else $error("outputs active while disabled");
  a_line_flag: assert property (ls_entry && ls_prev_q != ls_rep_q |=> flags_q[uospc_pkg::LS_BIT])  // R18
    else $error("line change flag missed");
  a_id_flag: assert property (prime_q[2] && mon_now[3] != mon_q[3] |=> flags_q[uospc_pkg::ID_BIT])  // R19
    else $error("identity flag missed");
  a_stat_wr: assert property (wr_stat |=> $stable(con_q) && $stable(pwrc_q))  // R20
    else $error("status write changed state");

  c_line_flag: cover property (flags_q[uospc_pkg::LS_BIT] && wr_flag && reg_wdata[5]);
  c_sw_pull:   cover property (pwr_en && con_q[uospc_pkg::SWP_BIT] ##1 pull_out != '0);
  c_busy_fall: cover property ($fell(busy));
  c_sleep_blk: cover property ($rose(sleep_block));

endmodule

// ---- uospc_cable_model.sv ----
// Far side of the cable: plugs a cable, supplies line state, bus power and bus activity.
module uospc_cable_model (
  // Clock.
  input  wire logic                   core_clk,
  // Scenario controls.
  input  wire logic                   a_cable,
  input  wire logic                   host_power,
  input  wire logic [7:0]             rise_cyc,
  input  wire logic [1:0]             line,
  input  wire logic                   wiggle,
  // Device side.
  input  wire uospc_pkg::uospc_vbus_t vbus_in,
  output uospc_pkg::uospc_pins_t      pins_out
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] rise_q;
  logic       present;
  logic       valid;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus power is supplied by the far host or by the device itself.
  assign present = host_power | vbus_in.bus_power_on;

  // A slow ramp keeps the valid comparators low for a while, as a real bus capacitance does.
  always_ff @(posedge core_clk) begin
    if (!present) begin
      rise_q <= 8'h00;
    end else if (rise_q != rise_cyc) begin
      rise_q <= rise_q + 8'h01;
    end
  end
  assign valid = present && (rise_q == rise_cyc);

  ////////////////////////////////////////////////////////////////////////////////
  // An A cable grounds the identity pin; session end is seen only on the B side.
  assign pins_out = '{id: ~a_cable, se0: line[1], jstate: line[0], sess_valid: valid,
                      sess_end: ~valid & ~a_cable, vbus_valid: valid & a_cable, activity: wiggle};
endmodule

// ---- test_uospc_top.sv ----
// Register-level testbench of the OTG status and power control block.
module test_uospc_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic                   core_clk;
  logic                   sys_rst;
  logic [7:0]             reg_addr;
  logic [31:0]            reg_wdata;
  logic                   reg_wr;
  logic                   reg_rd;
  logic [31:0]            reg_rdata;
  uospc_pkg::uospc_pins_t pins;
  uospc_pkg::uospc_pull_t hw_pull;
  logic                   act_irq_taken;
  uospc_pkg::uospc_pull_t pull_out;
  uospc_pkg::uospc_vbus_t vbus_out;
  logic                   usb_clk_en;
  logic                   xcvr_low_power;
  logic                   pins_owned;
  logic                   analog_en;
  logic                   sleep_block;
  logic                   a_cable;
  logic                   host_power;
  logic [7:0]             rise_cyc;
  logic [1:0]             line;
  logic                   wiggle;
  logic [7:0]             con_tab [4];
  logic [7:0]             c;
  int                     bad_count;
  int                     checks_done;
  int                     cyc;

  uospc_top #(.LINE_STABLE_CYCLES(16)) dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins_in(pins),
    .hw_pull(hw_pull), .act_irq_taken(act_irq_taken), .pull_out(pull_out), .vbus_out(vbus_out),
    .usb_clk_en(usb_clk_en), .xcvr_low_power(xcvr_low_power), .pins_owned(pins_owned),
    .analog_en(analog_en), .sleep_block(sleep_block));

  uospc_cable_model cable (.core_clk(core_clk), .a_cable(a_cable), .host_power(host_power),
    .rise_cyc(rise_cyc), .line(line), .wiggle(wiggle), .vbus_in(vbus_out), .pins_out(pins));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic print_verdict();
    if (bad_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // A hang is cut short well past the few hundred cycles the sequence needs.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      $display("MISMATCH t=%0t cycle limit reached", $time);
      print_verdict();
    end
  end

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  function automatic logic [31:0] outs();
    return {20'h0, pull_out, vbus_out, usb_clk_en, xcvr_low_power, pins_owned, analog_en, sleep_block};
  endfunction

  // Pull and bus power controls are forced off while the module is disabled.
  function automatic logic [31:0] exp_out(logic [3:0] p, logic [2:0] v, logic en, logic su, logic sb);
    return {20'h0, en ? p : 4'h0, en ? v : 3'h0, en & ~su, ~en | su, en, en, sb};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    hw_pull = 4'hA;
    act_irq_taken = 1'b0;
    a_cable = 1'b0;
    host_power = 1'b0;
    rise_cyc = 8'h06;
    line = 2'b01;
    wiggle = 1'b0;
    con_tab = '{8'hF3, 8'h94, 8'h66, 8'h2D};
    idle(16);
    sys_rst <= 1'b0;
    rchk(uospc_pkg::CON_OFF, 32'h0);
    rchk(uospc_pkg::PWRC_OFF, 32'h0);
    chk(outs(), exp_out(4'h0, 3'h0, 1'b0, 1'b0, 1'b0));
    idle(30);
    rchk(uospc_pkg::STAT_OFF, 32'hA4);
    wr(uospc_pkg::STAT_OFF, 32'hFFFFFFFF);
    rchk(uospc_pkg::STAT_OFF, 32'hA4);
    wr(uospc_pkg::FLAG_OFF, 32'hFF);
    line <= 2'b00;
    idle(3);
    rchk(uospc_pkg::STAT_OFF, 32'h84);
    idle(30);
    rchk(uospc_pkg::STAT_OFF, 32'hA4);
    rchk(uospc_pkg::FLAG_OFF, 32'h20);
    wr(uospc_pkg::FLAG_OFF, 32'h20);
    rchk(uospc_pkg::FLAG_OFF, 32'h0);
    a_cable <= 1'b1;
    idle(6);
    rchk(uospc_pkg::STAT_OFF, 32'h20);
    rchk(uospc_pkg::FLAG_OFF, 32'h84);
    wr(uospc_pkg::FLAG_OFF, 32'h84);
    wr(uospc_pkg::PWRC_OFF, 32'h01);
    rchk(uospc_pkg::PWRC_OFF, 32'h09);
    chk(outs(), exp_out(4'hA, 3'h0, 1'b1, 1'b0, 1'b0));
    for (int i = 0; i < 4; i++) begin
      c = con_tab[i];
      wr(uospc_pkg::CON_OFF, {24'h0, c});
      idle(3);
      chk(outs(), exp_out(c[2] ? c[7:4] : 4'hA, {c[3], c[1], c[0]}, 1'b1, 1'b0, 1'b0));
      rchk(uospc_pkg::CON_OFF, {24'h0, c});
    end
    idle(15);
    rchk(uospc_pkg::STAT_OFF, 32'h29);
    rchk(uospc_pkg::FLAG_OFF, 32'h09);
    wr(uospc_pkg::FLAG_OFF, 32'hFF);
    wr(uospc_pkg::PWRC_OFF, 32'h03);
    idle(3);
    chk(outs(), exp_out(4'h2, 3'h5, 1'b1, 1'b1, 1'b0));
    wr(uospc_pkg::PWRC_OFF, 32'h11);
    wiggle <= 1'b1;
    idle(2);
    wiggle <= 1'b0;
    idle(5);
    rchk(uospc_pkg::PWRC_OFF, 32'h99);
    chk({31'h0, sleep_block}, 32'h1);
    act_irq_taken <= 1'b1;
    idle(1);
    act_irq_taken <= 1'b0;
    idle(3);
    rchk(uospc_pkg::PWRC_OFF, 32'h19);
    chk({31'h0, sleep_block}, 32'h0);
    wr(uospc_pkg::PWRC_OFF, 32'h01);
    wiggle <= 1'b1;
    idle(2);
    wiggle <= 1'b0;
    idle(5);
    rchk(uospc_pkg::PWRC_OFF, 32'h89);
    chk({31'h0, sleep_block}, 32'h0);
    wr(uospc_pkg::PWRC_OFF, 32'h00);
    rchk(uospc_pkg::PWRC_OFF, 32'h88);
    chk(outs(), exp_out(4'h0, 3'h0, 1'b0, 1'b0, 1'b0));
    idle(10);
    act_irq_taken <= 1'b1;
    rchk(uospc_pkg::PWRC_OFF, 32'h00);
    act_irq_taken <= 1'b0;
    rchk(8'h10, 32'h0);
    wr(uospc_pkg::CON_OFF, 32'hFFFFFFFF);
    rchk(uospc_pkg::CON_OFF, 32'hFF);
    print_verdict();
  end
endmodule
